// ===== logic/dhps_ctrl.sv
// control state machine of the dual-host port selector
`timescale 1ns/1ps
`default_nettype none
module dhps_ctrl
  import dhps_pkg::*;
#(
  parameter logic                  ORDERLY_SWITCH = 1'h0,
  parameter logic [SPD_W-1:0]      MAX_SPEED      = MAX_SPEED_RST
) (
  input  wire logic                    CORE_CLK,
  input  wire logic                    RST_N,
  input  wire logic                    MODE_IN_BAND,
  input  wire logic                    OUT_OF_BAND_SELECT_MODE_SEL,
  input  wire logic                    LOCAL_RESET_REQ,
  input  wire dhps_pkg::dhps_oob_type  OOB_EVT,
  input  wire logic [1:0]              SEQ_DET,
  output dhps_pkg::dhps_phy_ctrl_type  PHY_CTRL,
  output logic [1:0]                   HOST_TX_EN,
  output logic                         FORWARD_EN,
  output logic                         SELECTED_HOST_PORT,
  output logic                         PORT_SELECT_EVENT,
  output logic [SPD_W-1:0]             MAX_NEGOTIATED_SPEED,
  output dhps_pkg::dhps_state_type     CTRL_STATE
);

  import dhps_pkg::*;

  ////////////////////////////////////////////////////////////////////////////
  // pin synchronisation and event decode

  logic [PIN_W-1:0] pin_s;
  dhps_regs_type    r;
  dhps_regs_type    n;
  logic             mode_ib;
  logic             sb_sel;
  logic             lrst;
  logic             comreset_sel;
  logic             host_a_oob;
  logic             host_b_oob;
  logic             sb_change;
  logic             seq_other;
  logic             change_req;
  logic             force_dev;
  logic             force_host;

  dhps_sync #(
    .W (PIN_W)
  ) u_pin_sync (
    .clk   (CORE_CLK),
    .d     ({LOCAL_RESET_REQ, OUT_OF_BAND_SELECT_MODE_SEL, MODE_IN_BAND}),
    .q     (pin_s)
  );

  assign mode_ib      = pin_s[PIN_MODE];
  assign sb_sel       = pin_s[PIN_SBSEL];
  assign lrst         = pin_s[PIN_LRST];
  assign comreset_sel = r.selected_host_port ? OOB_EVT.comreset_b : OOB_EVT.comreset_a;
  assign host_a_oob   = OOB_EVT.comreset_a | OOB_EVT.comwake_a;
  assign host_b_oob   = OOB_EVT.comreset_b | OOB_EVT.comwake_b;

  // side-band request only counts once a host has been linked
  assign sb_change  = !mode_ib && r.linked && (sb_sel != r.selected_host_port);
  assign seq_other  = r.selected_host_port ? SEQ_DET[PORT_A] : SEQ_DET[PORT_B];
  assign change_req = mode_ib ? seq_other : sb_change;

  // the await state decodes host oob itself, so the forced moves skip it
  assign force_dev  = comreset_sel
                      && (r.state != POWER_ON_RESET_STATE)
                      && (r.state != AWAIT_SELECTION_STATE);
  assign force_host = OOB_EVT.cominit_d && !force_dev
                      && (r.state != POWER_ON_RESET_STATE)
                      && (r.state != AWAIT_SELECTION_STATE)
                      && (r.state != DEVICE_RESET_STATE);

  ////////////////////////////////////////////////////////////////////////////
  // helpers

  function automatic dhps_regs_type init_regs(input logic sel);
    dhps_regs_type v;
    v                      = '0;
    v.state                = POWER_ON_RESET_STATE;
    v.selected_host_port   = sel;
    v.online               = ONLINE_RST;
    v.host_tx_en           = TX_EN_RST;
    v.max_negotiated_speed = MAX_SPEED;
    return v;
  endfunction : init_regs

  // after a change or a forced reset each mode returns to its own waiting state
  function automatic dhps_state_type settle_state(input logic ib);
    return ib ? WAIT_COMM_STATE : OUT_OF_BAND_SELECT_MODE_SELECT_STATE;
  endfunction : settle_state

  ////////////////////////////////////////////////////////////////////////////
  // next-state logic

  always_comb
  begin
    n                   = r;
    n.phy_reset_cmd     = 3'h0;
    n.port_select_event = mode_ib ? |SEQ_DET : sb_change;
    unique case (r.state)
      POWER_ON_RESET_STATE:
      begin
        n       = init_regs(SEL_RST);
        n.state = mode_ib ? AWAIT_SELECTION_STATE : OUT_OF_BAND_SELECT_MODE_SELECT_STATE;
      end
      OUT_OF_BAND_SELECT_MODE_SELECT_STATE:
      begin
        if (!r.linked)
        begin
          n.selected_host_port = sb_sel;
          n.online[PORT_D]     = 1'h1;
          n.fwd_en             = 1'h1;
          n.linked             = 1'h1;
          n.host_tx_en         = sb_sel ? 2'h2 : 2'h1;
          n.online[PORT_A]     = !sb_sel;
          n.online[PORT_B]     = sb_sel;
        end
        else if (change_req)
          n.state = CHG_QUIESCE_STATE;
      end
      AWAIT_SELECTION_STATE:
      begin
        if (host_a_oob)
        begin
          n.selected_host_port = 1'h0;
          n.state              = SELECT_HOST_STATE;
        end
        else if (host_b_oob)
        begin
          n.selected_host_port = 1'h1;
          n.state              = SELECT_HOST_STATE;
        end
        else if (OOB_EVT.cominit_d)
          n.state = INIT_FORWARD_BOTH_STATE;
      end
      INIT_FORWARD_BOTH_STATE:
      begin
        n.online[PORT_A]        = 1'h1;
        n.online[PORT_B]        = 1'h1;
        n.phy_reset_cmd[PORT_A] = 1'h1;
        n.phy_reset_cmd[PORT_B] = 1'h1;
        n.state                 = AWAIT_SELECTION_STATE;
      end
      SELECT_HOST_STATE:
      begin
        n.online[!r.selected_host_port]       = 1'h0;
        n.online[r.selected_host_port]        = 1'h1;
        n.online[PORT_D]                      = 1'h1;
        n.phy_reset_cmd[r.selected_host_port] = 1'h1;
        n.phy_reset_cmd[PORT_D]               = 1'h1;
        n.host_tx_en                          = r.selected_host_port ? 2'h2 : 2'h1;
        n.fwd_en                              = 1'h1;
        n.linked                              = 1'h1;
        n.state                               = WAIT_COMM_STATE;
      end
      WAIT_COMM_STATE:
      begin
        if (change_req)
          n.state = CHG_QUIESCE_STATE;
      end
      CHG_QUIESCE_STATE:
      begin
        n.host_tx_en                    = 2'h0;
        n.online[r.selected_host_port]  = 1'h0;
        n.fwd_en                        = 1'h0;
        n.selected_host_port            = !r.selected_host_port;
        n.state                         = CHG_INIT_STATE;
      end
      CHG_INIT_STATE:
      begin
        n = init_regs(r.selected_host_port);
        if (ORDERLY_SWITCH)
          n.online[PORT_D] = r.online[PORT_D];
        n.state = CHG_ACTIVATE_STATE;
      end
      CHG_ACTIVATE_STATE:
      begin
        n.online[r.selected_host_port] = 1'h1;
        n.online[PORT_D]               = 1'h1;
        n.host_tx_en                   = r.selected_host_port ? 2'h2 : 2'h1;
        n.state                        = CHG_OPEN_STATE;
      end
      CHG_OPEN_STATE:
      begin
        n.fwd_en = 1'h1;
        n.linked = 1'h1;
        n.state  = settle_state(mode_ib);
      end
      DEVICE_RESET_STATE:
      begin
        n.online[PORT_D]        = 1'h1;
        n.phy_reset_cmd[PORT_D] = 1'h1;
        n.state                 = settle_state(mode_ib);
      end
      HOST_RESET_STATE:
      begin
        n.phy_reset_cmd[r.selected_host_port] = 1'h1;
        n.state                               = settle_state(mode_ib);
      end
      default:
      begin
        n = init_regs(SEL_RST);
      end
    endcase
    // overrides, the side-band state relies on them for its reset exits
    if (force_dev)
      n.state = DEVICE_RESET_STATE;
    else if (force_host)
      n.state = HOST_RESET_STATE;
    // the local request is synchronised, so entry lags the pin by three edges
    if (lrst)
      n = init_regs(SEL_RST);
  end

  always_ff @(posedge CORE_CLK)
  begin
    if (!RST_N)
      r <= init_regs(SEL_RST);
    else
      r <= n;
  end

  ////////////////////////////////////////////////////////////////////////////
  // outputs

  assign PHY_CTRL = '{online        : r.online,
                      offline       : ~r.online,
                      phy_reset_cmd : r.phy_reset_cmd};
  assign HOST_TX_EN             = r.host_tx_en;
  assign FORWARD_EN             = r.fwd_en;
  assign SELECTED_HOST_PORT     = r.selected_host_port;
  assign PORT_SELECT_EVENT      = r.port_select_event;
  assign MAX_NEGOTIATED_SPEED   = r.max_negotiated_speed;
  assign CTRL_STATE             = r.state;

  ////////////////////////////////////////////////////////////////////////////
  // assertions

  default clocking cb @(posedge CORE_CLK);
  endclocking
  default disable iff (!RST_N);

  AST_QUIESCE_OLD: assert property (
    (r.state == CHG_QUIESCE_STATE) && !lrst
    |=> (r.host_tx_en == 2'h0) && !r.online[!r.selected_host_port] && !r.fwd_en)
    else $error("old host still active after quiesce step");

  AST_INIT_KEEPS_SEL: assert property (
    (r.state == CHG_INIT_STATE) && !lrst && !force_dev && !force_host
    |=> $stable(r.selected_host_port) && (r.state == CHG_ACTIVATE_STATE)
        && (r.host_tx_en == 2'h0))
    else $error("init step lost selection or state");

  AST_ACTIVATE_NEW: assert property (
    (r.state == CHG_ACTIVATE_STATE) && !lrst
    |=> r.online[r.selected_host_port] && !r.online[!r.selected_host_port])
    else $error("new host not online after activate step");

  AST_CHANGE_ORDER: assert property (
    (r.state == CHG_QUIESCE_STATE) && !lrst && !force_dev && !force_host
    |=> (r.state == CHG_INIT_STATE) && !r.fwd_en)
    else $error("change steps out of order");

  AST_OPEN_FWD: assert property (
    (r.state == CHG_OPEN_STATE) && !lrst |=> r.fwd_en && r.linked)
    else $error("forwarding not enabled after change");

  AST_ORDERLY_D: assert property (
    ORDERLY_SWITCH && (r.state == CHG_QUIESCE_STATE) && r.online[PORT_D]
    && !lrst && !force_dev && !force_host
    |=> r.online[PORT_D] [*3])
    else $error("device phy dropped during orderly switch");

  AST_FORCE_DEV: assert property (
    comreset_sel && !lrst && (r.state != POWER_ON_RESET_STATE)
    && (r.state != AWAIT_SELECTION_STATE)
    |=> (r.state == DEVICE_RESET_STATE) ##1 r.online[PORT_D])
    else $error("comreset did not force device reset");

  AST_FORCE_HOST: assert property (
    OOB_EVT.cominit_d && !comreset_sel && !lrst
    && (r.state inside {OUT_OF_BAND_SELECT_MODE_SELECT_STATE, WAIT_COMM_STATE, HOST_RESET_STATE})
    |=> (r.state == HOST_RESET_STATE))
    else $error("cominit did not force host reset");

  AST_POR_VALUES: assert property (
    (r.state == POWER_ON_RESET_STATE)
    |-> (r.online == 3'h0) && (r.max_negotiated_speed == MAX_SPEED) && !r.fwd_en)
    else $error("power-on state values wrong");

  AST_POR_HOLD: assert property (
    lrst |=> (r.state == POWER_ON_RESET_STATE))
    else $error("left power-on state while reset requested");

  AST_POR_EXIT: assert property (
    (r.state == POWER_ON_RESET_STATE) && !lrst
    |=> (r.state == ($past(mode_ib) ? AWAIT_SELECTION_STATE : OUT_OF_BAND_SELECT_MODE_SELECT_STATE)))
    else $error("wrong exit from power-on state");

  AST_SB_LOAD: assert property (
    (r.state == OUT_OF_BAND_SELECT_MODE_SELECT_STATE) && !r.linked && !lrst
    |=> (r.selected_host_port == $past(sb_sel)) && r.linked)
    else $error("side-band selection not loaded");

  AST_INIT_BOTH: assert property (
    (r.state == INIT_FORWARD_BOTH_STATE) && !lrst && !force_dev && !force_host
    |=> r.online[PORT_A] && r.online[PORT_B] && (r.phy_reset_cmd[1:0] == 2'h3)
        && (r.state == AWAIT_SELECTION_STATE))
    else $error("init not forwarded to both hosts");

  AST_AWAIT_PICK: assert property (
    (r.state == AWAIT_SELECTION_STATE) && host_a_oob && !lrst
    |=> (r.state == SELECT_HOST_STATE) && !r.selected_host_port)
    else $error("await state did not pick host A");

  AST_PSEL_IND: assert property (
    mode_ib && !lrst && (r.state != POWER_ON_RESET_STATE) && (r.state != CHG_INIT_STATE)
    |=> (r.port_select_event == $past(|SEQ_DET)))
    else $error("port-select indication mismatch");

  COV_CHANGE: cover property (
    (r.state == WAIT_COMM_STATE) ##1 (r.state == CHG_QUIESCE_STATE)
    ##3 (r.state == CHG_OPEN_STATE));
  COV_OUT_OF_BAND_SELECT_MODE_CHANGE: cover property (
    (r.state == OUT_OF_BAND_SELECT_MODE_SELECT_STATE) && sb_change ##1 (r.state == CHG_QUIESCE_STATE));
  COV_FORWARD_BOTH: cover property (
    (r.state == INIT_FORWARD_BOTH_STATE) ##1 (r.state == AWAIT_SELECTION_STATE));
  COV_DEV_RESET: cover property (r.state == DEVICE_RESET_STATE);

endmodule : dhps_ctrl
`default_nettype wire

// ===== logic/dhps_pkg.sv
// package: states, carriers and constants of the dual-host port selector control
package dhps_pkg;

  localparam int unsigned PORT_A = 0;
  localparam int unsigned PORT_B = 1;
  localparam int unsigned PORT_D = 2;
  localparam int unsigned SPD_W  = 2;
  localparam int unsigned PIN_W  = 3;
  localparam int unsigned PIN_MODE = 0;
  localparam int unsigned PIN_SBSEL = 1;
  localparam int unsigned PIN_LRST = 2;

  localparam logic [SPD_W-1:0] MAX_SPEED_RST = 2'h3;
  localparam logic             SEL_RST       = 1'h0;
  localparam logic [2:0]       ONLINE_RST    = 3'h0;
  localparam logic [1:0]       TX_EN_RST     = 2'h0;

  typedef enum logic [3:0] {
    POWER_ON_RESET_STATE    = 4'h0,
    OUT_OF_BAND_SELECT_MODE_SELECT_STATE   = 4'h1,
    AWAIT_SELECTION_STATE   = 4'h2,
    INIT_FORWARD_BOTH_STATE = 4'h3,
    SELECT_HOST_STATE       = 4'h4,
    WAIT_COMM_STATE         = 4'h5,
    CHG_QUIESCE_STATE       = 4'h6,
    CHG_INIT_STATE          = 4'h7,
    CHG_ACTIVATE_STATE      = 4'h8,
    CHG_OPEN_STATE          = 4'h9,
    DEVICE_RESET_STATE      = 4'hA,
    HOST_RESET_STATE        = 4'hB
  } dhps_state_type;

  // out-of-band events from the three port phys, one-cycle pulses
  typedef struct packed {
    logic comreset_a;
    logic comreset_b;
    logic comwake_a;
    logic comwake_b;
    logic cominit_d;
  } dhps_oob_type;

  // per-port phy controls, bit index is PORT_A/PORT_B/PORT_D
  typedef struct packed {
    logic [2:0] online;
    logic [2:0] offline;
    logic [2:0] phy_reset_cmd;
  } dhps_phy_ctrl_type;

  typedef struct packed {
    dhps_state_type   state;
    logic             selected_host_port;
    logic [2:0]       online;
    logic [2:0]       phy_reset_cmd;
    logic [1:0]       host_tx_en;
    logic             fwd_en;
    logic             port_select_event;
    logic             linked;
    logic [SPD_W-1:0] max_negotiated_speed;
  } dhps_regs_type;

endpackage : dhps_pkg

// ===== logic/dhps_sync.sv
// two-flop synchroniser for pins that come from outside the core clock
`timescale 1ns/1ps
`default_nettype none
module dhps_sync #(
  parameter int unsigned W = 1
) (
  input  wire logic         clk,
  input  wire logic [W-1:0] d,
  output logic      [W-1:0] q
);

  logic [W-1:0] meta_r;
  logic [W-1:0] sync_r;

  // meta_r feeds sync_r only; no reset on purpose, so the pin levels
  // have already settled when the core reset is released
  always_ff @(posedge clk)
  begin
    meta_r <= d;
    sync_r <= meta_r;
  end

  assign q = sync_r;

endmodule : dhps_sync
`default_nettype wire

// ===== bench/dhps_far_model.sv
// far-side model: both hosts and the storage device as sources of oob and selection events
`timescale 1ns/1ps
`default_nettype none
module dhps_far_model
  import dhps_pkg::*;
(
  input  wire logic                        clk,
  input  wire dhps_pkg::dhps_phy_ctrl_type phy_ctrl,
  output var  dhps_pkg::dhps_oob_type      oob,
  output var  logic [1:0]                  seq_det
);
  initial
  begin
    oob     = '0;
    seq_det = '0;
  end

  // lines drop back to idle at every edge, after the design has sampled them
  always @(posedge clk)
  begin
    oob     <= '0;
    seq_det <= '0;
  end

  ////////////////////////////////////////////////////////////////////////////////
  // one-cycle event after gap idle cycles; back to back calls never re-drive in one step
  task automatic pulse(input dhps_oob_type ev, input logic [1:0] sd, input int gap);
    repeat (gap) @(posedge clk);
    if (gap > 0)
      #1;
    oob     = ev;
    seq_det = sd;
    @(posedge clk);
    #1;
  endtask : pulse

  // a freshly active host resets the device once its phy is online
  task automatic new_host_comreset(input logic host);
    int n;
    n = 0;
    while (phy_ctrl.online[host] !== 1'h1 && n < 20)
    begin
      @(posedge clk);
      #1;
      n++;
    end
    pulse(host ? 5'h08 : 5'h10, 2'h0, 0);
  endtask : new_host_comreset
endmodule : dhps_far_model
`default_nettype wire

// ===== bench/tb_dual_host_port_selector_control.sv
// self-checking testbench of the port selector control state machine
`timescale 1ns/1ps
`default_nettype none
module tb_dual_host_port_selector_control;
  import dhps_pkg::*;
  logic              core_clk;
  logic              rst_n;
  logic              mode_in_band;
  logic              out_of_band_select_mode_sel;
  logic              local_reset_req;
  dhps_oob_type      oob;
  logic [1:0]        seq_det;
  dhps_phy_ctrl_type phy_ctrl;
  logic [1:0]        host_tx_en;
  logic              forward_en;
  logic              sel;
  logic              psel;
  logic [SPD_W-1:0]  speed;
  dhps_state_type    ctrl_state;
  int                err_count;
  int                total_checks;

  dhps_ctrl i_dhps_ctrl (
    .CORE_CLK(core_clk), .RST_N(rst_n), .MODE_IN_BAND(mode_in_band),
    .OUT_OF_BAND_SELECT_MODE_SEL(out_of_band_select_mode_sel), .LOCAL_RESET_REQ(local_reset_req), .OOB_EVT(oob),
    .SEQ_DET(seq_det), .PHY_CTRL(phy_ctrl), .HOST_TX_EN(host_tx_en),
    .FORWARD_EN(forward_en), .SELECTED_HOST_PORT(sel), .PORT_SELECT_EVENT(psel),
    .MAX_NEGOTIATED_SPEED(speed), .CTRL_STATE(ctrl_state)
  );

  dhps_far_model i_dhps_far_model (
    .clk(core_clk), .phy_ctrl(phy_ctrl), .oob(oob), .seq_det(seq_det)
  );

  initial core_clk = 1'h0;
  always #2.5 core_clk = ~core_clk;

  ////////////////////////////////////////////////////////////////////////////////
  task automatic check(input logic [8:0] seen, input logic [8:0] exp);
    total_checks++;
    if (seen !== exp)
    begin
      err_count++;
      $display("MISMATCH t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask : check

  task automatic results;
    $display("checks=%0d mismatches=%0d", total_checks, err_count);
    if (err_count == 0 && total_checks > 0)
      $display("Regression OK");
    else
      $display("Regression broken");
    $finish;
  endtask : results

  task automatic step;
    @(posedge core_clk);
    #1;
  endtask : step

  // bounded wait, a miss counts as a mismatch
  task automatic wait_st(input dhps_state_type st);
    int n;
    n = 0;
    while (ctrl_state !== st && n < 20)
    begin
      step();
      n++;
    end
    check(ctrl_state, st);
  endtask : wait_st

  task automatic do_reset(input logic mode, input logic sb);
    mode_in_band = mode;
    out_of_band_select_mode_sel = sb;
    rst_n        = 1'h0;
    repeat (2) step();
    rst_n = 1'h1;
  endtask : do_reset

  // caller stands at the first cycle of the change
  task automatic change_walk(input logic n, input dhps_state_type fin);
    check(ctrl_state, CHG_QUIESCE_STATE);
    check(psel, 1'h1);
    step();
    check(host_tx_en, 2'h0);
    check(phy_ctrl.online[~n], 1'h0);
    check(forward_en, 1'h0);
    check(sel, n);
    step();
    check(phy_ctrl.online, 3'h0);
    check(sel, n);
    step();
    check(phy_ctrl.online, n ? 3'h6 : 3'h5);
    check(host_tx_en, n ? 2'h2 : 2'h1);
    check(forward_en, 1'h0);
    step();
    check(forward_en, 1'h1);
    check(ctrl_state, fin);
  endtask : change_walk

  ////////////////////////////////////////////////////////////////////////////////
  task automatic t_por;
    do_reset(1'h0, 1'h0);
    check(ctrl_state, POWER_ON_RESET_STATE);
    check(phy_ctrl.online, 3'h0);
    check(phy_ctrl.offline, 3'h7);
    check({host_tx_en, forward_en, psel}, 4'h0);
    check(speed, MAX_SPEED_RST);
    step();
    check(ctrl_state, OUT_OF_BAND_SELECT_MODE_SELECT_STATE);
    step();
    check(ctrl_state, OUT_OF_BAND_SELECT_MODE_SELECT_STATE);
    $display("test por done");
  endtask : t_por

  task automatic t_out_of_band_select_mode;
    do_reset(1'h0, 1'h1);
    wait_st(OUT_OF_BAND_SELECT_MODE_SELECT_STATE);
    step();
    check(sel, 1'h1);
    check(phy_ctrl.online, 3'h6);
    check(forward_en, 1'h1);
    out_of_band_select_mode_sel = 1'h0;
    wait_st(CHG_QUIESCE_STATE);
    change_walk(1'h0, OUT_OF_BAND_SELECT_MODE_SELECT_STATE);
    i_dhps_far_model.pulse(5'h10, 2'h0, 2);
    check(ctrl_state, DEVICE_RESET_STATE);
    $display("test out_of_band_select_mode done");
  endtask : t_out_of_band_select_mode

  task automatic t_select;
    logic [4:0] ev [3];
    logic       exp [3];
    ev  = '{5'h12, 5'h02, 5'h03};
    exp = '{1'h0, 1'h1, 1'h1};
    for (int i = 0; i < 3; i++)
    begin
      do_reset(1'h1, 1'h0);
      wait_st(AWAIT_SELECTION_STATE);
      i_dhps_far_model.pulse(ev[i], 2'h0, i);
      check(ctrl_state, SELECT_HOST_STATE);
      step();
      check(sel, exp[i]);
      check(phy_ctrl.online, exp[i] ? 3'h6 : 3'h5);
      check(phy_ctrl.phy_reset_cmd, exp[i] ? 3'h6 : 3'h5);
      check(host_tx_en, exp[i] ? 2'h2 : 2'h1);
      check(ctrl_state, WAIT_COMM_STATE);
    end
    $display("test select done");
  endtask : t_select

  task automatic t_change;
    do_reset(1'h1, 1'h0);
    wait_st(AWAIT_SELECTION_STATE);
    i_dhps_far_model.pulse(5'h04, 2'h0, 0);
    step();
    i_dhps_far_model.pulse(5'h00, 2'h1, 0);
    check(psel, 1'h1);
    step();
    check(psel, 1'h0);
    check(ctrl_state, WAIT_COMM_STATE);
    i_dhps_far_model.pulse(5'h00, 2'h2, 1);
    change_walk(1'h1, WAIT_COMM_STATE);
    i_dhps_far_model.new_host_comreset(1'h1);
    check(ctrl_state, DEVICE_RESET_STATE);
    $display("test change done");
  endtask : t_change

  task automatic t_forced;
    do_reset(1'h1, 1'h0);
    wait_st(AWAIT_SELECTION_STATE);
    i_dhps_far_model.pulse(5'h04, 2'h0, 0);
    step();
    i_dhps_far_model.pulse(5'h08, 2'h0, 0);
    check(ctrl_state, WAIT_COMM_STATE);
    i_dhps_far_model.pulse(5'h10, 2'h0, 0);
    check(ctrl_state, DEVICE_RESET_STATE);
    i_dhps_far_model.pulse(5'h01, 2'h0, 0);
    check(ctrl_state, WAIT_COMM_STATE);
    check(phy_ctrl.phy_reset_cmd, 3'h4);
    check(phy_ctrl.online, 3'h5);
    i_dhps_far_model.pulse(5'h01, 2'h0, 0);
    check(ctrl_state, HOST_RESET_STATE);
    step();
    check(phy_ctrl.phy_reset_cmd, 3'h1);
    $display("test forced done");
  endtask : t_forced

  task automatic t_init_both;
    do_reset(1'h1, 1'h0);
    wait_st(AWAIT_SELECTION_STATE);
    i_dhps_far_model.pulse(5'h01, 2'h0, 1);
    check(ctrl_state, INIT_FORWARD_BOTH_STATE);
    step();
    check(phy_ctrl.online, 3'h3);
    check(phy_ctrl.phy_reset_cmd, 3'h3);
    check(ctrl_state, AWAIT_SELECTION_STATE);
    $display("test init_both done");
  endtask : t_init_both

  task automatic t_local;
    do_reset(1'h0, 1'h1);
    wait_st(OUT_OF_BAND_SELECT_MODE_SELECT_STATE);
    step();
    local_reset_req = 1'h1;
    wait_st(POWER_ON_RESET_STATE);
    repeat (4) step();
    check(ctrl_state, POWER_ON_RESET_STATE);
    check({phy_ctrl.online, forward_en, sel}, 5'h00);
    local_reset_req = 1'h0;
    wait_st(OUT_OF_BAND_SELECT_MODE_SELECT_STATE);
    check(speed, MAX_SPEED_RST);
    $display("test local_reset done");
  endtask : t_local

  ////////////////////////////////////////////////////////////////////////////////
  initial
  begin
    err_count       = 0;
    total_checks    = 0;
    rst_n           = 1'h0;
    mode_in_band    = 1'h0;
    out_of_band_select_mode_sel    = 1'h0;
    local_reset_req = 1'h0;
    step();
    t_por();
    t_out_of_band_select_mode();
    t_select();
    t_change();
    t_forced();
    t_init_both();
    t_local();
    results();
  end

  // whole run is under a hundred cycles; give it ample margin
  initial
  begin
    #25000;
    err_count++;
    results();
  end
endmodule : tb_dual_host_port_selector_control
`default_nettype wire
